// ---- hdl/fntc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fntc_top #(
   parameter int unsigned FRAC_W = fntc_pkg::FRAC_W
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [18:0]      n_int_o,
   output logic [FRAC_W-1:0] n_frac_o,
   output logic             frac_carry_o,
   output logic [13:0]      ref_div_o,
   output logic             prescale_div2_o,
   output logic [2:0]       out_div_sel_o,
   output logic             out_div_bypass_o,
   output logic             modulator_on_o
);
   typedef enum logic [0:0] {W_IDLE = 1'b0, W_RESP = 1'b1} fntc_wst_type;

   fntc_pkg::fntc_cfg_type cfg, next_cfg;
   fntc_wst_type           wst, next_wst;
   logic                   aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0]             aw_addr, next_aw_addr;
   logic [31:0]            w_data, next_w_data;
   logic [1:0]             bresp, next_bresp;
   logic                   rvalid, next_rvalid;
   logic [31:0]            rdata, next_rdata;
   logic [1:0]             rresp, next_rresp;
   logic [FRAC_W-1:0]      acc, next_acc;
   logic [13:0]            step_cnt, next_step_cnt;
   logic                   carry, next_carry;
   logic                   int_mode;

   function automatic logic known_addr(input logic [7:0] a);
      unique case (a)
         fntc_pkg::IDX_REF_DIV << 2, fntc_pkg::IDX_INT_DIV << 2, fntc_pkg::IDX_FRAC_DIV << 2,
         fntc_pkg::IDX_VCO_FWD << 2, fntc_pkg::IDX_MOD_CFG << 2, fntc_pkg::IDX_PRESCALE << 2,
         fntc_pkg::IDX_EXACT << 2, fntc_pkg::IDX_STATUS << 2: known_addr = 1'b1;
         default: known_addr = 1'b0;
      endcase
   endfunction : known_addr

   assign s_axi_awready = (wst == W_IDLE) && !aw_held;
   assign s_axi_wready  = (wst == W_IDLE) && !w_held;
   assign s_axi_bvalid  = (wst == W_RESP);
   assign s_axi_bresp   = bresp;
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;

   // integer mode only when modulator disabled and bypassed
   assign int_mode = !cfg.mod_en && cfg.mod_bypass;

   always_comb begin
      next_wst     = wst;
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_bresp   = bresp;
      next_cfg     = cfg;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
      end
      if (wst == W_IDLE && next_aw_held && next_w_held) begin
         next_wst     = W_RESP;
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bresp   = known_addr(next_aw_addr) ? fntc_pkg::RESP_OKAY : fntc_pkg::RESP_SLVERR;
         // whole-word writes; byte strobes ignored since fields span lanes
         unique case (next_aw_addr)
            fntc_pkg::IDX_REF_DIV << 2: next_cfg.ref_div = next_w_data[13:0];
            fntc_pkg::IDX_INT_DIV << 2: next_cfg.int_div = next_w_data[18:0];
            fntc_pkg::IDX_FRAC_DIV << 2: next_cfg.frac_div = next_w_data[23:0];
            // vco output divider reachable only via this forwarding word
            fntc_pkg::IDX_VCO_FWD << 2:
               next_cfg.out_div = next_w_data[fntc_pkg::FWD_LO +: fntc_pkg::ODIV_W];
            fntc_pkg::IDX_MOD_CFG << 2: begin
               next_cfg.mod_en     = next_w_data[fntc_pkg::MOD_EN_BIT];
               next_cfg.mod_bypass = next_w_data[fntc_pkg::MOD_BYP_BIT];
            end
            fntc_pkg::IDX_PRESCALE << 2: next_cfg.prescale_div2 = next_w_data[fntc_pkg::PRE_BIT];
            fntc_pkg::IDX_EXACT << 2: next_cfg.exact_steps = next_w_data[13:0];
            default: ;
         endcase
      end else if (wst == W_RESP && s_axi_bready) begin
         next_wst = W_IDLE;
      end
   end

   always_comb begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = known_addr(s_axi_araddr) ? fntc_pkg::RESP_OKAY : fntc_pkg::RESP_SLVERR;
         next_rdata  = 32'h0000_0000;
         unique case (s_axi_araddr)
            fntc_pkg::IDX_REF_DIV << 2:  next_rdata[13:0] = cfg.ref_div;
            fntc_pkg::IDX_INT_DIV << 2:  next_rdata[18:0] = cfg.int_div;
            fntc_pkg::IDX_FRAC_DIV << 2: next_rdata[23:0] = cfg.frac_div;
            fntc_pkg::IDX_VCO_FWD << 2:  next_rdata[fntc_pkg::FWD_LO +: fntc_pkg::ODIV_W] = cfg.out_div;
            fntc_pkg::IDX_MOD_CFG << 2: begin
               next_rdata[fntc_pkg::MOD_EN_BIT]  = cfg.mod_en;
               next_rdata[fntc_pkg::MOD_BYP_BIT] = cfg.mod_bypass;
            end
            fntc_pkg::IDX_PRESCALE << 2: next_rdata[fntc_pkg::PRE_BIT] = cfg.prescale_div2;
            fntc_pkg::IDX_EXACT << 2:    next_rdata[13:0] = cfg.exact_steps;
            fntc_pkg::IDX_STATUS << 2:   next_rdata = {16'h0000, 1'b0, int_mode, step_cnt};
            default: ;
         endcase
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // first-order accumulator on the comparison clock, fixed 2^24 modulus
   always_comb begin
      next_acc      = acc;
      next_carry    = 1'b0;
      next_step_cnt = step_cnt;
      if (int_mode) begin
         next_acc      = '0;
         next_step_cnt = 14'h0000;
      end else begin
         {next_carry, next_acc} = {1'b0, acc} + {1'b0, cfg.frac_div};
         if (cfg.exact_steps != 14'h0000) begin
            // step counter wraps at programmed count; acc length untouched
            if (step_cnt >= cfg.exact_steps - 14'h0001)
               next_step_cnt = 14'h0000;
            else
               next_step_cnt = step_cnt + 14'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wst       <= W_IDLE;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr   <= 8'h00;
         w_data    <= 32'h0000_0000;
         bresp     <= 2'h0;
         rvalid    <= 1'b0;
         rdata     <= 32'h0000_0000;
         rresp     <= 2'h0;
         acc       <= '0;
         carry     <= 1'b0;
         step_cnt  <= 14'h0000;
         cfg       <= '{int_div: fntc_pkg::INT_RST, frac_div: 24'h000000, ref_div: fntc_pkg::REF_RST,
                        exact_steps: 14'h0000, out_div: 3'h0, mod_en: 1'b1, mod_bypass: 1'b0,
                        prescale_div2: 1'b0};
      end else begin
         wst      <= next_wst;
         aw_held  <= next_aw_held;
         w_held   <= next_w_held;
         aw_addr  <= next_aw_addr;
         w_data   <= next_w_data;
         bresp    <= next_bresp;
         rvalid   <= next_rvalid;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
         acc      <= next_acc;
         carry    <= next_carry;
         step_cnt <= next_step_cnt;
         cfg      <= next_cfg;
      end
   end

   // integer below 16 clamps: ratio floor of the divider
   assign n_int_o          = (cfg.int_div < fntc_pkg::INT_MIN) ? fntc_pkg::INT_MIN : cfg.int_div;
   assign n_frac_o         = int_mode ? '0 : cfg.frac_div;
   assign frac_carry_o     = carry;
   assign ref_div_o        = cfg.ref_div;
   assign prescale_div2_o  = cfg.prescale_div2;
   assign out_div_sel_o    = cfg.out_div;
   assign out_div_bypass_o = (cfg.out_div == 3'h0);
   assign modulator_on_o   = !int_mode;

   int_mode_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      int_mode |=> (acc == '0 && !carry)) else $error("accumulator runs in integer mode");
   int_floor_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      n_int_o >= fntc_pkg::INT_MIN) else $error("integer ratio below floor");
   frac_add_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !int_mode && !$past(int_mode) && $stable(cfg.frac_div) |-> ##1
      ({carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(cfg.frac_div)}))
      else $error("fraction accumulation wrong");
   // a shrunken count may leave the counter high for the one cycle of the change
   step_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cfg.exact_steps != 14'h0000 |-> step_cnt < cfg.exact_steps || $changed(cfg.exact_steps))
      else $error("step count exceeds programmed count");
   // aw_addr and w_data stay captured while the response is pending
   fwd_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(s_axi_bvalid) && aw_addr == (fntc_pkg::IDX_VCO_FWD << 2) |->
      out_div_sel_o == w_data[fntc_pkg::FWD_LO +: fntc_pkg::ODIV_W])
      else $error("forwarded divider not applied");
   bypass_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(s_axi_bvalid) && aw_addr == (fntc_pkg::IDX_VCO_FWD << 2) |->
      out_div_bypass_o == (w_data[fntc_pkg::FWD_LO +: fntc_pkg::ODIV_W] == 3'h0))
      else $error("bypass route mismatch");
   mode_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      modulator_on_o == (cfg.mod_en || !cfg.mod_bypass)) else $error("mode decode wrong");
   bresp_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rvalid_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ref_apply_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(s_axi_bvalid) && aw_addr == (fntc_pkg::IDX_REF_DIV << 2) |->
      ref_div_o == w_data[fntc_pkg::REF_W-1:0]) else $error("reference ratio not applied");

   wr_cov_c: cover property (@(posedge clk_sys_i) s_axi_bvalid && s_axi_bready);
   rd_cov_c: cover property (@(posedge clk_sys_i) s_axi_rvalid && s_axi_rready);
   carry_cov_c: cover property (@(posedge clk_sys_i) frac_carry_o);
   wrap_cov_c: cover property (@(posedge clk_sys_i) cfg.exact_steps != 14'h0000 && step_cnt == 14'h0000
      && $past(step_cnt) != 14'h0000);
endmodule : fntc_top
`default_nettype wire

// ---- hdl/fntc_pkg.sv ----
`default_nettype none
package fntc_pkg;
   localparam int unsigned ADDR_W = 8;
   // register word indices; the byte address is the index times four
   localparam logic [7:0] IDX_REF_DIV   = 8'h02;
   localparam logic [7:0] IDX_INT_DIV   = 8'h03;
   localparam logic [7:0] IDX_FRAC_DIV  = 8'h04;
   localparam logic [7:0] IDX_VCO_FWD   = 8'h05;
   localparam logic [7:0] IDX_MOD_CFG   = 8'h06;
   localparam logic [7:0] IDX_PRESCALE  = 8'h08;
   localparam logic [7:0] IDX_EXACT     = 8'h0c;
   localparam logic [7:0] IDX_STATUS    = 8'h10;
   localparam int unsigned INT_W        = 19;
   localparam int unsigned FRAC_W       = 24;
   localparam int unsigned REF_W        = 14;
   localparam int unsigned EXACT_W      = 14;
   localparam int unsigned ODIV_W       = 3;
   localparam int unsigned MOD_EN_BIT   = 11;
   localparam int unsigned MOD_BYP_BIT  = 7;
   localparam int unsigned PRE_BIT      = 19;
   localparam int unsigned FWD_LO       = 7;
   localparam logic [18:0] INT_MIN      = 19'h00010;
   localparam logic [18:0] INT_RST      = 19'h00014;
   localparam logic [13:0] REF_RST      = 14'h0001;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef struct packed {
      logic [INT_W-1:0]   int_div;
      logic [FRAC_W-1:0]  frac_div;
      logic [REF_W-1:0]   ref_div;
      logic [EXACT_W-1:0] exact_steps;
      logic [ODIV_W-1:0]  out_div;
      logic               mod_en;
      logic               mod_bypass;
      logic               prescale_div2;
   } fntc_cfg_type;
endpackage : fntc_pkg
`default_nettype wire

// ---- bench/fntc_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module fntc_top_test;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic [7:0]  awaddr    = 8'h00;
   logic [7:0]  araddr    = 8'h00;
   logic [31:0] wdata     = 32'h0;
   logic        awvalid   = 1'b0;
   logic        wvalid    = 1'b0;
   logic        bready    = 1'b0;
   logic        arvalid   = 1'b0;
   logic        rready    = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, carry, pre, byp, mon;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [18:0] n_int;
   logic [23:0] n_frac;
   logic [13:0] ref_div;
   logic [2:0]  sel;
   int          n_mismatch = 0;
   int          checked    = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   fntc_top fntc_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .n_int_o(n_int), .n_frac_o(n_frac),
      .frac_carry_o(carry), .ref_div_o(ref_div), .prescale_div2_o(pre), .out_div_sel_o(sel),
      .out_div_bypass_o(byp), .modulator_on_o(mon));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = fntc_pkg::RESP_OKAY);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
      @(posedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk_sys_i);
   endtask : rd

   task automatic count_carry(output int n);
      n = 0;
      repeat (64) begin
         @(posedge clk_sys_i);
         if (carry === 1'b1) n++;
      end
   endtask : count_carry

   task automatic t_reset;
      chk(32'(n_int), 32'h14);
      chk(32'(ref_div), 32'h1);
      chk({28'h0, sel, byp}, 32'h1);
      chk({30'h0, mon, pre}, 32'h2);
   endtask : t_reset

   task automatic t_int;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h0c, 32'h5);
      chk(32'(n_int), 32'h10);
      wr(8'h0c, 32'h7ffff);
      chk(32'(n_int), 32'h7ffff);
      wr(8'h0c, 32'h46);
      rd(8'h0c, d, r);
      chk(d, 32'h46);
      chk(32'(r), 32'(fntc_pkg::RESP_OKAY));
      chk(32'(n_int), 32'h46);
   endtask : t_int

   task automatic t_mode;
      logic [31:0] d;
      logic [1:0]  r;
      logic        on;
      wr(8'h10, 32'h19999a);
      for (int i = 0; i < 4; i++) begin
         on = (i != 1);
         wr(8'h18, (32'(i / 2) << 11) | (32'(i % 2) << 7));
         chk(32'(mon), 32'(on));
         chk(32'(n_frac), on ? 32'h19999a : 32'h0);
         rd(8'h40, d, r);
         chk(32'(d[14]), 32'(!on));
      end
   endtask : t_mode

   task automatic t_carry;
      int n;
      wr(8'h18, 32'h800);
      wr(8'h10, 32'h400000);
      count_carry(n);
      chk(32'(n), 32'd16);
      wr(8'h18, 32'h80); // offset current sits outside this block
      count_carry(n);
      chk(32'(n), 32'd0);
   endtask : t_carry

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h08, 32'h3fff);
      rd(8'h08, d, r);
      chk(d, 32'h3fff);
      chk(32'(ref_div), 32'h3fff);
      wr(8'h20, 32'h80000);
      chk(32'(pre), 32'h1);
      wr(8'h20, 32'h0);
      chk(32'(pre), 32'h0);
      wr(8'h30, 32'hc00);
      rd(8'h30, d, r);
      chk(d, 32'hc00);
      rd(8'h40, d, r);
      chk(d, 32'h4000);
      // counter leaves zero at the edge after the modulator comes on
      wr(8'h18, 32'h800);
      rd(8'h40, d, r);
      chk(d, 32'h2);
      wr(8'h30, 32'h3);
      rd(8'h40, d, r);
      chk(32'(d[13:0] < 14'h3), 32'h1);
   endtask : t_regs

   task automatic t_vco;
      // neighbouring bits set to prove only 9:7 feed the divider code
      for (int c = 0; c < 8; c++) begin
         wr(8'h14, (32'(c) << 7) | 32'hfffffc7f); // divider chosen with the modulator already enabled
         chk(32'(sel), 32'(c));
         chk(32'(byp), 32'(c == 0));
      end
   endtask : t_vco

   task automatic t_bad;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h3c, 32'ha5a5a5a5, fntc_pkg::RESP_SLVERR);
      rd(8'h3c, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(fntc_pkg::RESP_SLVERR));
   endtask : t_bad

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
      t_int();
      t_mode();
      t_carry();
      t_regs();
      t_vco();
      t_bad();
      stop_test();
   end

   // whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      stop_test();
   end
endmodule : fntc_top_test
`default_nettype wire
